// ===== src/unev_event_core.sv
// event and interrupt aggregation for the usb node controller
`timescale 1ns/10ps
`default_nettype none
module unev_event_core
    import unev_pkg::*;
#(
    parameter int NUM_EP        = 4,
    parameter int SE0_CNT       = SE0_CYCLES,
    parameter int SHORT_IDLE_CNT = SHORT_IDLE_CYCLES,
    parameter int LONG_IDLE_CNT  = LONG_IDLE_CYCLES
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    // cpu register port
    input  wire logic [3:0]        cpu_addr,
    input  wire logic              cpu_rd,
    input  wire logic              cpu_wr,
    input  wire logic [7:0]        cpu_wdata,
    output logic      [7:0]        cpu_rdata,
    // serial engine and fifo event sources (one-cycle pulses unless noted; node state and wake pending inputs are levels)
    input  wire logic [NUM_EP-1:0] tx_done_set,
    input  wire logic [NUM_EP-1:0] tx_underflow_set,
    input  wire logic [NUM_EP-1:0] rx_last_set,
    input  wire logic [NUM_EP-1:0] rx_error_set,
    input  wire logic [NUM_EP-1:0] rx_overflow_set,
    input  wire logic              eop_seen,
    input  wire logic              bus_idle,       // level: upstream idle
    input  wire logic              bus_se0,        // level: single-ended zero
    input  wire logic [1:0]        node_state_field,
    input  wire logic              cpu_wake_pending,
    input  wire logic              bus_wake_pending,
    input  wire logic              transfer_engine_event, // level: unmasked dma event
    output logic                   irq
);
    logic [7:0]        top_event_enable_reg;   // main mask, bit7 global enable
    logic [7:0]        secondary_enable_reg;
    logic [7:0]        transmit_enable_reg;
    logic [7:0]        receive_enable_reg;
    logic [7:0]        sec_sticky;             // clear-on-read secondary flags
    logic [NUM_EP-1:0] tx_complete_copy;
    logic [NUM_EP-1:0] tx_underflow_copy;
    logic [NUM_EP-1:0] rx_complete_copy;
    logic [NUM_EP-1:0] rx_overflow_bits;
    logic [NUM_EP-1:0] rx_error_bits;          // held for the rx status view
    logic              wake_flag;
    logic              dma_flag;
    logic              secondary_summary;
    logic              short_hit;
    logic              long_hit;
    logic              se0_hit;
    logic              unused_hit;
    logic              resume_arm;             // blocks repeat resume sets
    logic [7:0]        secondary_event_reg;
    logic [7:0]        transmit_event_reg;
    logic [7:0]        receive_event_reg;
    logic [7:0]        top_event_reg;
    logic              transmit_summary;
    logic              receive_summary;
    logic [7:0]        next_rdata;
    logic              rd_sec;
    logic              rd_rx;
    logic [NUM_EP-1:0] rx_st_rd;               // per-endpoint rx status read strobes

    // pad an endpoint vector into a nibble
    function automatic logic [3:0] nib(input logic [NUM_EP-1:0] v);
        logic [3:0] r;
        r = '0;
        r[NUM_EP-1:0] = v;
        return r;
    endfunction : nib

    // one-hot endpoint select for status reads at a base index
    function automatic logic [NUM_EP-1:0] ep_read(input logic [3:0] base);
        logic [NUM_EP-1:0] r;
        r = '0;
        for (int i = 0; i < NUM_EP; i++) begin
            r[i] = cpu_rd && (cpu_addr == base + 4'(i));
        end
        return r;
    endfunction : ep_read

    assign rd_sec = cpu_rd && (cpu_addr == ADDR_SEC_EVENT);
    assign rd_rx  = cpu_rd && (cpu_addr == ADDR_RX_EVENT);
    always_comb begin
        rx_st_rd = ep_read(ADDR_RX_STATUS0);
    end

    ////////////////////////////////////////////////////////////////////////////
    // idle and reset timers; the 3 ms and 5 ms share one count of idle
    unev_line_timer #(
        .CNT_W   (24),
        .THRESH1 (SHORT_IDLE_CNT),
        .THRESH2 (LONG_IDLE_CNT)
    ) u_idle_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cond    (bus_idle),
        .hit1    (short_hit),
        .hit2    (long_hit)
    );

    unev_line_timer #(
        .CNT_W   (8),
        .THRESH1 (SE0_CNT),
        .THRESH2 (SE0_CNT + 1)
    ) u_se0_timer (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .cond    (bus_se0),
        .hit1    (se0_hit),
        .hit2    (unused_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writable enable registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            top_event_enable_reg <= RESET_BYTE;
            secondary_enable_reg <= RESET_BYTE;
            transmit_enable_reg  <= RESET_BYTE;
            receive_enable_reg   <= RESET_BYTE;
        end else if (cpu_wr) begin
            case (cpu_addr)
                ADDR_TOP_ENABLE: top_event_enable_reg <= cpu_wdata;
                ADDR_SEC_ENABLE: secondary_enable_reg <= cpu_wdata;
                ADDR_TX_ENABLE:  transmit_enable_reg  <= cpu_wdata;
                ADDR_RX_ENABLE:  receive_enable_reg   <= cpu_wdata;
                default: ;  // event registers ignore writes
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clear-on-read secondary flags; a set in the read cycle wins over the clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sec_sticky <= RESET_BYTE;
            resume_arm <= 1'b1;
        end else begin
            if (rd_sec) begin
                sec_sticky <= RESET_BYTE;
            end
            if (eop_seen) sec_sticky[BIT_EOP] <= 1'b1;
            if (short_hit) sec_sticky[BIT_SHORT_IDLE] <= 1'b1;
            if (long_hit) sec_sticky[BIT_LONG_IDLE] <= 1'b1;
            if (se0_hit) sec_sticky[BIT_BUS_RESET] <= 1'b1;
            // resume fires once per departure from idle while suspended
            if (node_state_field == UNEV_NODE_SUSP && !bus_idle && resume_arm) begin
                sec_sticky[BIT_RESUME] <= 1'b1;
            end
            resume_arm <= bus_idle || (node_state_field != UNEV_NODE_SUSP);
        end
    end

    // wake and dma flags follow their sources rather than reads
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wake_flag <= 1'b0;
            dma_flag  <= 1'b0;
        end else begin
            // wake is shown only while the global enable bit of the top mask is set
            wake_flag <= (cpu_wake_pending || bus_wake_pending)
                         && top_event_enable_reg[BIT_GLOBAL_EN];
            dma_flag  <= transfer_engine_event;
        end
    end

    always_comb begin
        secondary_event_reg            = sec_sticky;
        secondary_event_reg[BIT_WAKE]  = wake_flag;
        secondary_event_reg[BIT_DMA]   = dma_flag;
        secondary_event_reg[0]         = 1'b0;   // reserved
    end

    ////////////////////////////////////////////////////////////////////////////
    // secondary summary: sticky, cleared by reading the secondary register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            secondary_summary <= 1'b0;
        end else if (|(secondary_event_reg & secondary_enable_reg) && !rd_sec) begin
            secondary_summary <= 1'b1;
        end else if (rd_sec) begin
            secondary_summary <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-endpoint transmit copies, cleared by reading that tx status
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_complete_copy  <= '0;
            tx_underflow_copy <= '0;
        end else begin
            tx_complete_copy  <= (tx_complete_copy & ~ep_read(ADDR_TX_STATUS0))
                                 | tx_done_set;
            tx_underflow_copy <= (tx_underflow_copy & ~ep_read(ADDR_TX_STATUS0))
                                 | tx_underflow_set;
            tx_underflow_copy[0] <= 1'b0;  // store and forward cannot underrun
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive copies: complete clears on rx status read, overflow on event read
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_complete_copy <= '0;
            rx_overflow_bits <= '0;
            rx_error_bits    <= '0;
        end else begin
            rx_complete_copy <= (rx_complete_copy & ~ep_read(ADDR_RX_STATUS0))
                                | rx_last_set | rx_error_set;
            // endpoint 0 errored packets are dropped, so only last counts
            rx_complete_copy[0] <= (rx_complete_copy[0] & ~rx_st_rd[0])
                                   | rx_last_set[0];
            rx_overflow_bits <= (rx_overflow_bits & ~{NUM_EP{rd_rx}})
                                | rx_overflow_set;
            rx_error_bits    <= (rx_error_bits & ~ep_read(ADDR_RX_STATUS0))
                                | rx_error_set;
        end
    end

    assign transmit_event_reg = {nib(tx_underflow_copy), nib(tx_complete_copy)};
    assign receive_event_reg  = {nib(rx_overflow_bits), nib(rx_complete_copy)};

    // summaries track their sources, so they fall once all bits are cleared
    assign transmit_summary = |(transmit_event_reg & transmit_enable_reg);
    assign receive_summary  = |(receive_event_reg & receive_enable_reg);

    always_comb begin
        top_event_reg                  = RESET_BYTE;
        top_event_reg[BIT_RX_SUMMARY]  = receive_summary;
        top_event_reg[BIT_TX_SUMMARY]  = transmit_summary;
        top_event_reg[BIT_SEC_SUMMARY] = secondary_summary;
        top_event_reg[BIT_GLOBAL_EN]   = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: global enable and any unmasked top event
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= top_event_enable_reg[BIT_GLOBAL_EN]
                   && |(top_event_reg & top_event_enable_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data mux; registered so data appears the edge after the read strobe
    always_comb begin
        next_rdata = RESET_BYTE;
        case (cpu_addr)
            ADDR_TOP_EVENT:  next_rdata = top_event_reg;
            ADDR_TOP_ENABLE: next_rdata = top_event_enable_reg;
            ADDR_SEC_EVENT:  next_rdata = secondary_event_reg;
            ADDR_SEC_ENABLE: next_rdata = secondary_enable_reg;
            ADDR_TX_EVENT:   next_rdata = transmit_event_reg;
            ADDR_TX_ENABLE:  next_rdata = transmit_enable_reg;
            ADDR_RX_EVENT:   next_rdata = receive_event_reg;
            ADDR_RX_ENABLE:  next_rdata = receive_enable_reg;
            default: begin
                // status views: bit0 done/last, bit1 underflow/error
                for (int i = 0; i < NUM_EP; i++) begin
                    if (cpu_addr == ADDR_TX_STATUS0 + 4'(i)) begin
                        next_rdata = {6'h00, tx_underflow_copy[i], tx_complete_copy[i]};
                    end
                    if (cpu_addr == ADDR_RX_STATUS0 + 4'(i)) begin
                        next_rdata = {6'h00, rx_error_bits[i], rx_complete_copy[i]};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cpu_rdata <= RESET_BYTE;
        end else if (cpu_rd) begin
            cpu_rdata <= next_rdata;
        end
    end
endmodule : unev_event_core
`default_nettype wire

// ===== src/unev_pkg.sv
// constants shared by the usb node event hierarchy block
package unev_pkg;
    // register indices on the parallel cpu port (chosen map)
    localparam logic [3:0] ADDR_TOP_EVENT     = 4'h0;
    localparam logic [3:0] ADDR_TOP_ENABLE    = 4'h1;
    localparam logic [3:0] ADDR_SEC_EVENT     = 4'h2;
    localparam logic [3:0] ADDR_SEC_ENABLE    = 4'h3;
    localparam logic [3:0] ADDR_TX_EVENT      = 4'h4;
    localparam logic [3:0] ADDR_TX_ENABLE     = 4'h5;
    localparam logic [3:0] ADDR_RX_EVENT      = 4'h6;
    localparam logic [3:0] ADDR_RX_ENABLE     = 4'h7;
    localparam logic [3:0] ADDR_TX_STATUS0    = 4'h8;  // tx status regs at 8..b
    localparam logic [3:0] ADDR_RX_STATUS0    = 4'hc;  // rx status regs at c..f
    // top event register bit positions
    localparam int BIT_GLOBAL_EN    = 7;
    localparam int BIT_RX_SUMMARY   = 6;
    localparam int BIT_TX_SUMMARY   = 2;
    localparam int BIT_SEC_SUMMARY  = 1;
    // secondary event register bit positions
    localparam int BIT_RESUME       = 7;
    localparam int BIT_BUS_RESET    = 6;
    localparam int BIT_LONG_IDLE    = 5;
    localparam int BIT_SHORT_IDLE   = 4;
    localparam int BIT_EOP          = 3;
    localparam int BIT_DMA          = 2;
    localparam int BIT_WAKE         = 1;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // timing: clock period and idle / reset detection times
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int SE0_TIME_PS      = 2500000;   // 2.5 us
    localparam int SHORT_IDLE_US    = 3000;      // 3 ms
    localparam int LONG_IDLE_US     = 5000;      // 5 ms
    // least times round up to whole cycles
    localparam int SE0_CYCLES        = (SE0_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SHORT_IDLE_CYCLES = (SHORT_IDLE_US * 1000 + CLK_PERIOD_PS / 1000 - 1)
                                       / (CLK_PERIOD_PS / 1000);
    localparam int LONG_IDLE_CYCLES  = (LONG_IDLE_US * 1000 + CLK_PERIOD_PS / 1000 - 1)
                                       / (CLK_PERIOD_PS / 1000);
    // node state encodings
    typedef enum logic [1:0] {
        UNEV_NODE_RESET  = 2'b00,
        UNEV_NODE_RESUME = 2'b01,
        UNEV_NODE_OPER   = 2'b10,
        UNEV_NODE_SUSP   = 2'b11
    } unev_node_t;
endpackage : unev_pkg

// ===== src/unev_line_timer.sv
// bus line condition timer: counts a held condition and pulses once at each threshold
`timescale 1ns/10ps
`default_nettype none
module unev_line_timer
    import unev_pkg::*;
#(
    parameter int CNT_W   = 18,
    parameter int THRESH1 = 120000,
    parameter int THRESH2 = 200000
) (
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic cond,
    output logic      hit1,
    output logic      hit2
);
    logic [CNT_W-1:0] count;   // cycles the condition has held

    ////////////////////////////////////////////////////////////////////////////
    // count saturates one above the larger threshold so each hit fires once
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (count <= CNT_W'(THRESH2)) begin
            count <= count + CNT_W'(1);
        end
    end

    // one-cycle pulses when the count passes each threshold
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            hit1 <= 1'b0;
            hit2 <= 1'b0;
        end else begin
            hit1 <= cond && (count == CNT_W'(THRESH1 - 1));
            hit2 <= cond && (count == CNT_W'(THRESH2 - 1));
        end
    end
endmodule : unev_line_timer
`default_nettype wire

// ===== bench/unev_cpu_model.sv
// external cpu model: register port strobes and node state writes
`timescale 1ns/10ps
`default_nettype none
module unev_cpu_model
    import unev_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic [7:0] cpu_rdata,
    output var  logic [3:0] cpu_addr,
    output var  logic       cpu_rd,
    output var  logic       cpu_wr,
    output var  logic [7:0] cpu_wdata,
    output var  logic [1:0] node_state_field
);
    // idle port and an operating node from time zero
    initial begin
        cpu_addr = 4'h0;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_wdata = 8'h00;
        node_state_field = UNEV_NODE_OPER;
    end
    // one write strobe, one cycle wide
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cpu_wr <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge clk_sys);
        cpu_wr <= 1'b0;
    endtask : wr
    // two reads on consecutive edges; data taken mid-cycle once settled
    task automatic rd(input logic [3:0] a, b, output logic [7:0] x, y);
        @(posedge clk_sys);
        cpu_rd <= 1'b1;
        cpu_addr <= a;
        @(posedge clk_sys);
        cpu_addr <= b;
        @(negedge clk_sys);
        x = cpu_rdata;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
        @(negedge clk_sys);
        y = cpu_rdata;
    endtask : rd
    // after a bus reset the node sits in reset for the given hold
    task automatic node_reset(input int hold);
        @(posedge clk_sys);
        node_state_field <= UNEV_NODE_RESET;
        repeat (hold) @(posedge clk_sys);
        node_state_field <= UNEV_NODE_OPER;
    endtask : node_reset
    // suspend or remote wake is always entered by firmware itself
    task automatic node_set(input unev_node_t s);
        @(posedge clk_sys);
        node_state_field <= s;
    endtask : node_set
endmodule : unev_cpu_model
`default_nettype wire

// ===== bench/unev_event_checker.sv
// concurrent checks on the event core ports
`timescale 1ns/10ps
`default_nettype none
module unev_event_checker
    import unev_pkg::*;
#(
    parameter int NUM_EP = 4
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [3:0]        cpu_addr,
    input  wire logic              cpu_rd,
    input  wire logic              cpu_wr,
    input  wire logic [7:0]        cpu_wdata,
    input  wire logic [7:0]        cpu_rdata,
    input  wire logic [NUM_EP-1:0] tx_done_set,
    input  wire logic [NUM_EP-1:0] tx_underflow_set,
    input  wire logic [NUM_EP-1:0] rx_last_set,
    input  wire logic [NUM_EP-1:0] rx_overflow_set,
    input  wire logic              eop_seen,
    input  wire logic              irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic [7:0] sh [4]; // shadows of the masks at indices 1,3,5,7
    logic       rd0, rd2, rd4, rd6, rdc;
    assign rd0 = cpu_rd && cpu_addr == ADDR_TOP_EVENT;
    assign rd2 = cpu_rd && cpu_addr == ADDR_SEC_EVENT;
    assign rd4 = cpu_rd && cpu_addr == ADDR_TX_EVENT;
    assign rd6 = cpu_rd && cpu_addr == ADDR_RX_EVENT;
    assign rdc = cpu_rd && cpu_addr == ADDR_RX_STATUS0;
    // mask shadows follow cpu writes so readback and gating can be judged
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sh <= '{default: 8'h00};
        end else if (cpu_wr && !cpu_addr[3] && cpu_addr[0]) begin
            sh[cpu_addr[2:1]] <= cpu_wdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    property p_top_msb;
        rd0 |=> !cpu_rdata[BIT_GLOBAL_EN];
    endproperty
    a_top_msb: assert property (p_top_msb) else $error("top event msb set");
    property p_mask_rb;
        cpu_rd && !cpu_wr && !cpu_addr[3] && cpu_addr[0]
            |=> cpu_rdata[7:1] == sh[$past(cpu_addr[2:1])][7:1];
    endproperty
    a_mask_rb: assert property (p_mask_rb) else $error("mask readback");
    // two quiet cycles of a cleared global enable must leave irq low
    property p_irq_gate;
        !sh[0][BIT_GLOBAL_EN] && !$past(sh[0][BIT_GLOBAL_EN]) |-> !irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
    property p_eop_cor;
        rd2 && !eop_seen ##1 rd2 |=> !cpu_rdata[BIT_EOP];
    endproperty
    a_eop_cor: assert property (p_eop_cor) else $error("eop kept after read");
    property p_urun0;
        rd4 |=> !cpu_rdata[4];
    endproperty
    a_urun0: assert property (p_urun0) else $error("ep0 underflow set");
    property p_ovf_cor;
        rd6 && rx_overflow_set == '0 ##1 rd6 |=> cpu_rdata[7:4] == 4'h0;
    endproperty
    a_ovf_cor: assert property (p_ovf_cor) else $error("overflow kept");
    property p_ep0_rx;
        rdc && !rx_last_set[0] ##1 rd6 |=> !cpu_rdata[0];
    endproperty
    a_ep0_rx: assert property (p_ep0_rx) else $error("ep0 rx complete");
    // summary seen one read later equals the OR of the masked event byte
    property p_tx_sum;
        rd4 && tx_done_set == '0 && tx_underflow_set == '0 && !cpu_wr ##1 rd0 && !cpu_wr
            |=> cpu_rdata[BIT_TX_SUMMARY] == |($past(cpu_rdata) & sh[2]);
    endproperty
    a_tx_sum: assert property (p_tx_sum) else $error("tx summary");
    c_irq: cover property (irq);
    c_sec_rd: cover property (rd2 ##1 rd2);
    c_tx_sum: cover property (rd4 ##1 rd0);
endmodule : unev_event_checker
bind unev_event_core unev_event_checker #(.NUM_EP(NUM_EP)) u_chk (
    .clk_sys, .reset_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .tx_done_set, .tx_underflow_set, .rx_last_set, .rx_overflow_set, .eop_seen, .irq
);
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the usb node event core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import unev_pkg::*;
    localparam int NODE_RST_CYC = 4000; // 100 us at 25 ns
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic [3:0] cpu_addr;
    logic       cpu_rd, cpu_wr, irq;
    logic [7:0] cpu_wdata, cpu_rdata, x, y;
    logic [3:0] tx_done_set = '0, tx_underflow_set = '0, rx_last_set = '0;
    logic [3:0] rx_error_set = '0, rx_overflow_set = '0;
    logic       eop_seen = 1'b0, bus_idle = 1'b0, bus_se0 = 1'b0;
    logic       cpu_wake_pending = 1'b0, bus_wake_pending = 1'b0;
    logic       transfer_engine_event = 1'b0;
    logic [1:0] node_state_field;
    int         err_count = 0, n_tests = 0;
    // short timer counts keep the run brief
    unev_event_core #(.NUM_EP(4), .SE0_CNT(4), .SHORT_IDLE_CNT(20), .LONG_IDLE_CNT(40)) uut (
        .clk_sys, .reset_n, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
        .tx_done_set, .tx_underflow_set, .rx_last_set, .rx_error_set, .rx_overflow_set,
        .eop_seen, .bus_idle, .bus_se0, .node_state_field, .cpu_wake_pending,
        .bus_wake_pending, .transfer_engine_event, .irq);
    unev_cpu_model cpu (.clk_sys, .cpu_rdata, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata,
        .node_state_field);
    always #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // one-cycle set pulses from the serial engine and fifos
    task automatic pulse(input logic [3:0] td, tu, rl, re, ro);
        @(posedge clk_sys);
        {tx_done_set, tx_underflow_set, rx_last_set, rx_error_set, rx_overflow_set} <=
            {td, tu, rl, re, ro};
        @(posedge clk_sys);
        {tx_done_set, tx_underflow_set, rx_last_set, rx_error_set, rx_overflow_set} <= '0;
    endtask : pulse
    task automatic t_masks();
        cpu.rd(ADDR_TOP_ENABLE, ADDR_SEC_ENABLE, x, y);
        chk("top mask reset", x, 8'h00);
        chk("sec mask reset", y, 8'h00);
        cpu.wr(ADDR_TOP_ENABLE, 8'h46);
        cpu.wr(ADDR_SEC_ENABLE, 8'hfe);
        cpu.wr(ADDR_TX_EVENT, 8'hff); // read-only place, must be ignored
        cpu.rd(ADDR_TOP_ENABLE, ADDR_TX_EVENT, x, y);
        chk("top mask", x, 8'h46);
        chk("tx event after write", y, 8'h00);
        cpu.wr(ADDR_TOP_ENABLE, 8'h00);
        cpu.wr(ADDR_SEC_ENABLE, 8'h00);
        $display("t_masks done");
    endtask : t_masks
    task automatic t_tx();
        pulse(4'h2, 4'h5, 4'h0, 4'h0, 4'h0);
        cpu.rd(ADDR_TX_EVENT, ADDR_TX_STATUS0 + 4'h1, x, y);
        chk("tx event", x, 8'h42);
        cpu.rd(ADDR_TX_EVENT, ADDR_TX_STATUS0 + 4'h2, x, y);
        chk("tx event after status", x, 8'h40);
        cpu.rd(ADDR_TX_EVENT, ADDR_TX_EVENT, x, y);
        chk("tx event cleared", x, 8'h00);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rx();
        pulse(4'h0, 4'h0, 4'h0, 4'h3, 4'h8);
        cpu.rd(ADDR_RX_EVENT, ADDR_RX_EVENT, x, y);
        chk("rx event", x, 8'h82);
        chk("rx overflow read-cleared", y, 8'h02);
        cpu.rd(ADDR_RX_EVENT, ADDR_RX_STATUS0 + 4'h1, x, y);
        chk("rx overflow cleared", x, 8'h02);
        chk("rx status error", y, 8'h03);
        pulse(4'h0, 4'h0, 4'h1, 4'h0, 4'h0);
        cpu.rd(ADDR_RX_EVENT, ADDR_TOP_EVENT, x, y);
        chk("rx ep0 last", x, 8'h01);
        chk("rx summary masked", y, 8'h00);
        cpu.rd(ADDR_RX_STATUS0, ADDR_RX_EVENT, x, y);
        chk("rx complete cleared", y, 8'h00);
        cpu.wr(ADDR_RX_ENABLE, 8'h10);
        pulse(4'h0, 4'h0, 4'h0, 4'h0, 4'h1);
        cpu.rd(ADDR_TOP_EVENT, ADDR_RX_EVENT, x, y);
        chk("rx summary", x, 8'h40);
        cpu.rd(ADDR_TOP_EVENT, ADDR_RX_ENABLE, x, y);
        chk("rx summary cleared", x, 8'h00);
        cpu.wr(ADDR_RX_ENABLE, 8'h00);
        $display("t_rx done");
    endtask : t_rx
    task automatic t_irq();
        cpu.wr(ADDR_TX_ENABLE, 8'h01);
        cpu.wr(ADDR_TOP_ENABLE, 8'h84);
        pulse(4'h1, 4'h0, 4'h0, 4'h0, 4'h0);
        repeat (3) @(posedge clk_sys);
        chk("irq enabled", {7'h00, irq}, 8'h01);
        cpu.wr(ADDR_TOP_ENABLE, 8'h04);
        repeat (3) @(posedge clk_sys);
        chk("irq global off", {7'h00, irq}, 8'h00);
        cpu.wr(ADDR_TOP_ENABLE, 8'h80);
        repeat (3) @(posedge clk_sys);
        chk("irq masked", {7'h00, irq}, 8'h00);
        cpu.rd(ADDR_TX_EVENT, ADDR_TOP_EVENT, x, y);
        chk("tx summary", y, 8'h04);
        cpu.rd(ADDR_TX_STATUS0, ADDR_TOP_EVENT, x, y);
        chk("tx summary cleared", y, 8'h00);
        cpu.wr(ADDR_TX_ENABLE, 8'h00);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_sec();
        cpu.wr(ADDR_SEC_ENABLE, 8'h40);
        bus_se0 <= 1'b1;
        repeat (10) @(posedge clk_sys);
        bus_se0 <= 1'b0;
        cpu.rd(ADDR_TOP_EVENT, ADDR_SEC_EVENT, x, y);
        chk("sec summary", x, 8'h02);
        chk("bus reset flag", y, 8'h40);
        cpu.node_reset(NODE_RST_CYC);
        cpu.rd(ADDR_TOP_EVENT, ADDR_TOP_EVENT, x, y);
        chk("sec summary cleared", x, 8'h00);
        @(posedge clk_sys);
        bus_idle <= 1'b1;
        repeat (25) @(posedge clk_sys);
        cpu.node_set(UNEV_NODE_SUSP);
        repeat (25) @(posedge clk_sys);
        eop_seen <= 1'b1;
        bus_idle <= 1'b0; // bus activity while suspended
        @(posedge clk_sys);
        eop_seen <= 1'b0;
        cpu.node_set(UNEV_NODE_RESUME);
        cpu.rd(ADDR_TOP_EVENT, ADDR_SEC_EVENT, x, y);
        chk("masked sec summary", x, 8'h00);
        chk("sec flags", y, 8'hb8);
        cpu.rd(ADDR_SEC_EVENT, ADDR_SEC_EVENT, x, y);
        chk("sec flags cleared", x, 8'h00);
        @(posedge clk_sys);
        cpu_wake_pending <= 1'b1;
        transfer_engine_event <= 1'b1;
        repeat (3) @(posedge clk_sys);
        cpu.rd(ADDR_SEC_EVENT, ADDR_SEC_EVENT, x, y);
        chk("wake and dma kept", y, 8'h06);
        @(posedge clk_sys);
        {cpu_wake_pending, bus_wake_pending, transfer_engine_event} <= 3'b010;
        repeat (3) @(posedge clk_sys);
        cpu.rd(ADDR_SEC_EVENT, ADDR_SEC_EVENT, x, y);
        chk("bus wake only", x, 8'h02);
        @(posedge clk_sys);
        bus_wake_pending <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cpu.rd(ADDR_SEC_EVENT, ADDR_SEC_EVENT, x, y);
        chk("wake cleared", x, 8'h00);
        $display("t_sec done");
    endtask : t_sec
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    // main sequence after five cycles of reset
    initial begin
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_masks();
        t_tx();
        t_rx();
        t_irq();
        t_sec();
        summarize();
    end
    // watchdog well beyond the roughly 4200 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
